// ==== dv/mcs_conv_model.sv ====
// converter model: one done pulse per start pulse
// assumes no start before the previous done
`timescale 1ns/10ps
`default_nettype none
module mcs_conv_model #(
	parameter LAT = 3
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       conv_start_q,
	input  wire logic [9:0] base,
	output var  logic       conv_done,
	output var  logic [9:0] conv_data
);
	logic [3:0] wait_q;
	logic [1:0] cnt_q;
	logic       busy_q;
	// ********
	// sample stream
	// ********
	// samples step by one, so any four average to base+1
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			conv_done <= 1'b0;
			conv_data <= 10'h000;
			wait_q <= 4'h0;
			cnt_q <= 2'h0;
			busy_q <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			// data not held outside the done cycle
			conv_data <= ~conv_data;
			if (conv_start_q) begin
				busy_q <= 1'b1;
				wait_q <= 4'(LAT);
			end else if (busy_q && wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end else if (busy_q) begin
				busy_q <= 1'b0;
				conv_done <= 1'b1;
				conv_data <= base + {8'h00, cnt_q};
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/mcs_top_asserts.sv ====
// checker for the monitor converter control block
// assumes binding onto mcs_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module mcs_top_asserts (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr_en,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_rd_en,
	input wire logic [7:0] reg_rdata_q,
	input wire logic       chg_req,
	input wire logic       conv_done,
	input wire logic       result_valid_q,
	input wire logic       irq_q,
	input wire logic       chg_data_ready_q,
	input wire logic       done_charger_q
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// ********
	// properties
	// ********
	property p_irq;
		irq_q |=> !irq_q;
	endproperty
	a_irq: assert property (p_irq) else $error("irq longer than one cycle");
	property p_chg_busy;
		chg_req |=> !done_charger_q;
	endproperty
	a_chg_busy: assert property (p_chg_busy) else $error("charger busy not shown");
	property p_chg_rdy;
		chg_data_ready_q |-> ##[0:1] done_charger_q;
	endproperty
	a_chg_rdy: assert property (p_chg_rdy) else $error("charger done not set");
	property p_lo;
		reg_rd_en && reg_addr == 8'h10 |=> reg_rdata_q[5:0] == 6'h00;
	endproperty
	a_lo: assert property (p_lo) else $error("threshold low spare bits set");
	property p_avg;
		reg_rd_en && reg_addr == 8'h0e |=> reg_rdata_q[7:6] == 2'h0;
	endproperty
	a_avg: assert property (p_avg) else $error("averaging spare bits set");
	property p_start0;
		reg_rd_en && reg_addr[7:1] == 7'h09 |=> !reg_rdata_q[5];
	endproperty
	a_start0: assert property (p_start0) else $error("start bit reads one");
	property p_res;
		result_valid_q |-> $past(conv_done);
	endproperty
	a_res: assert property (p_res) else $error("result without sample");
	// a read right behind a start must already show the run
	property p_busy;
		reg_wr_en && reg_addr == 8'h12 && reg_wdata[5] ##1 reg_rd_en && reg_addr == 8'h12
			|=> reg_rdata_q[0] && !reg_rdata_q[1];
	endproperty
	a_busy: assert property (p_busy) else $error("start not seen in status");
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// testbench for mcs_top with a behavioural converter
// assumes settling shortened to one cycle per microsecond
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr_en = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_rd_en = 1'b0;
	logic        rt_start_pin = 1'b0;
	logic        usb_req = 1'b0;
	logic        chg_req = 1'b0;
	logic [15:0] sw1_sel = 16'h0000;
	logic [15:0] sw2_sel = 16'h0000;
	logic [15:0] rt_sel = 16'h0000;
	logic [15:0] usb_sel = 16'h0000;
	logic [15:0] chg_sel = 16'h0000;
	logic [15:0] sw1_avg = 16'h0000;
	logic [15:0] rt_avg = 16'h0000;
	logic [7:0]  sw2_avg_low = 8'h00;
	logic [9:0]  battery_threshold = 10'h000;
	wire  [7:0]  reg_rdata_q;
	wire         conv_start_q;
	wire  [3:0]  conv_channel_q;
	wire  [15:0] conv_settle_q;
	wire         conv_done;
	wire  [9:0]  conv_data;
	wire         result_valid_q;
	wire  [3:0]  result_channel_q;
	wire  [2:0]  result_source_q;
	wire  [9:0]  result_data_q;
	wire         irq_q;
	wire         chg_data_ready_q;
	wire         done_charger_q;
	int          num_errors = 0;
	int          checks_done = 0;
	int          n_start = 0;
	int          n_irq = 0;
	int          n_rdy = 0;
	int          n0;
	logic [15:0] last_settle;
	logic [3:0]  last_ch;
	logic [2:0]  res_src;
	logic [9:0]  res_d [16];
	logic [7:0]  rd_val;

	always #50 clk_sys = ~clk_sys;

	mcs_top #(.CYCLES_PER_US(1)) mcs_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata_q(reg_rdata_q),
		.rt_start_pin(rt_start_pin), .usb_req(usb_req), .chg_req(chg_req), .sw1_sel(sw1_sel),
		.sw2_sel(sw2_sel), .rt_sel(rt_sel), .usb_sel(usb_sel), .chg_sel(chg_sel), .sw1_avg(sw1_avg),
		.rt_avg(rt_avg), .sw2_avg_low(sw2_avg_low), .battery_threshold(battery_threshold),
		.conv_start_q(conv_start_q), .conv_channel_q(conv_channel_q), .conv_settle_q(conv_settle_q),
		.conv_done(conv_done), .conv_data(conv_data), .result_valid_q(result_valid_q),
		.result_channel_q(result_channel_q), .result_source_q(result_source_q),
		.result_data_q(result_data_q), .irq_q(irq_q), .chg_data_ready_q(chg_data_ready_q),
		.done_charger_q(done_charger_q));
	mcs_conv_model mcs_conv_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .conv_start_q(conv_start_q),
		.base(10'h200), .conv_done(conv_done), .conv_data(conv_data));

	// ********
	// monitor and helpers
	// ********
	always @(negedge clk_sys) begin
		if (conv_start_q === 1'b1) begin
			n_start++;
			last_settle = conv_settle_q;
			last_ch = conv_channel_q;
		end
		if (result_valid_q === 1'b1) begin
			res_d[result_channel_q] = result_data_q;
			res_src = result_source_q;
		end
		if (irq_q === 1'b1) n_irq++;
		if (chg_data_ready_q === 1'b1) n_rdy++;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		// back-to-back writes: let one edge pass, strobe driven once per step
		if (reg_wr_en)
			@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		@(negedge clk_sys);
		rd_val = reg_rdata_q;
		@(posedge clk_sys);
		chk(16'(rd_val), 16'(e));
	endtask
	// sel 1 waits on charger ready, else on irq
	task wait_for(input int sel, input int k);
		int i;
		i = 0;
		while ((sel == 1 ? n_rdy : n_irq) < k && i < 3000) begin
			@(posedge clk_sys);
			i++;
		end
		chk(16'(i < 3000), 16'h0001);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ********
	// main sequence
	// ********
	initial begin
		#2000000;
		num_errors++;
		finish_test;
	end
	task test_reset_values;
		rdc(8'h0d, 8'h00);
		rdc(8'h0f, 8'h07);
		rdc(8'h10, 8'hc0);
		rdc(8'h11, 8'h8c);
		rdc(8'h12, 8'hde);
		rdc(8'h13, 8'hde);
		chk(16'(done_charger_q), 16'h0001);
	endtask
	task test_reg_fields;
		wr(8'h0e, 8'hff);
		rdc(8'h0e, 8'h3f);
		wr(8'h10, 8'hff);
		rdc(8'h10, 8'hc0);
		wr(8'h12, 8'hdf);
		rdc(8'h12, 8'hde);
	endtask
	task test_sw_two;
		// second software: ch8 averaged, ch12 compared
		wr(8'h11, 8'h7f);
		battery_threshold <= 10'h203;
		sw2_sel <= 16'h1100;
		wr(8'h0d, 8'h01);
		n0 = n_start;
		wr(8'h13, 8'h20);
		rdc(8'h13, 8'hdd);
		wait_for(0, n_irq + 1);
		chk(16'(n_start - n0), 16'd5);
		chk(last_settle, 16'd12);
		chk(16'(res_d[8]), 16'h0201);
		chk(16'(res_src), 16'h0001);
		rdc(8'h13, 8'h5e);
		rdc(8'h12, 8'h5e);
	endtask
	task test_sw_one;
		// first software with a refused settle write
		wr(8'h0f, 8'h02);
		sw1_sel <= 16'h0008;
		sw1_avg <= 16'h0008;
		n0 = n_start;
		wr(8'h12, 8'h20);
		rdc(8'h12, 8'h5d);
		wr(8'h0f, 8'h05);
		rdc(8'h0f, 8'h02);
		wait_for(0, n_irq + 1);
		chk(16'(n_start - n0), 16'd4);
		chk(last_settle, 16'd7);
		chk(16'(res_d[3]), 16'h0201);
		chk(16'(last_ch), 16'h0003);
		chk(16'(res_src), 16'h0000);
		rdc(8'h12, 8'h5e);
		wr(8'h0f, 8'h13);
		rdc(8'h0f, 8'h13);
	endtask
	task test_realtime;
		// realtime, high nibble settling
		rt_sel <= 16'h0020;
		rt_avg <= 16'h0020;
		n0 = n_start;
		rt_start_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rdc(8'h12, 8'h5b);
		rdc(8'h13, 8'h5b);
		wait_for(0, n_irq + 1);
		rt_start_pin <= 1'b0;
		chk(last_settle, 16'd72);
		chk(16'(n_start - n0), 16'd4);
		chk(16'(last_ch), 16'h0005);
		rdc(8'h13, 8'h5e);
	endtask
	task test_chg_usb;
		// charger and usb together, charger first
		wr(8'h0e, 8'h22);
		usb_sel <= 16'h0001;
		chg_sel <= 16'h0002;
		n0 = n_start;
		usb_req <= 1'b1;
		chg_req <= 1'b1;
		@(posedge clk_sys);
		usb_req <= 1'b0;
		chg_req <= 1'b0;
		@(negedge clk_sys);
		chk(16'(done_charger_q), 16'h0000);
		@(posedge clk_sys);
		rdc(8'h12, 8'h4f);
		wait_for(1, n_rdy + 1);
		chk(16'(res_src), 16'h0004);
		chk(16'(res_d[1]), 16'h0201);
		chk(last_settle, 16'd20);
		wait_for(0, n_irq + 1);
		chk(16'(res_src), 16'h0003);
		chk(16'(res_d[0]), 16'h0201);
		chk(16'(n_start - n0), 16'd8);
		chk(last_settle, 16'd20);
		rdc(8'h12, 8'h5e);
	endtask

	// ********
	// run
	// ********
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		test_reset_values;
		test_reg_fields;
		test_sw_two;
		test_sw_one;
		test_realtime;
		test_chg_usb;
		finish_test;
	end
endmodule
bind mcs_top mcs_top_asserts mcs_top_asserts_inst (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata_q(reg_rdata_q),
	.chg_req(chg_req), .conv_done(conv_done), .result_valid_q(result_valid_q), .irq_q(irq_q),
	.chg_data_ready_q(chg_data_ready_q), .done_charger_q(done_charger_q));
`default_nettype wire

// ==== logic/mcs_consts.vh ====
// constants for the monitor converter control and status block
// assumes the register port supplies an 8-bit register offset
`ifndef MCS_CONSTS_VH
`define MCS_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define MCS_ADDR_AVG_TWO_HIGH  8'h0d
`define MCS_ADDR_CHG_USB_AVG   8'h0e
`define MCS_ADDR_SETTLE        8'h0f
`define MCS_ADDR_THR_LOW       8'h10
`define MCS_ADDR_THR_HIGH      8'h11
`define MCS_ADDR_CTRL_ONE      8'h12
`define MCS_ADDR_CTRL_TWO      8'h13

// ****************************************
// reset values
// ****************************************
`define MCS_RST_SETTLE         8'h07
`define MCS_RST_THR_LOW        2'h3
`define MCS_RST_THR_HIGH       8'h8c
`define MCS_RST_AVG            8'h00

// ****************************************
// field positions
// ****************************************
`define MCS_BIT_AVG_CH8        0
`define MCS_BIT_AVG_CH12       4
`define MCS_BIT_USB_AVG_CH0    5
`define MCS_BIT_CHG_AVG_CH4    4
`define MCS_BIT_CHG_AVG_CH1    1
`define MCS_BIT_START          5
`define MCS_THR_LOW_MSB        7
`define MCS_THR_LOW_LSB        6

// ****************************************
// source indices, channel numbers
// ****************************************
`define MCS_SRC_SW1            3'h0
`define MCS_SRC_SW2            3'h1
`define MCS_SRC_RT             3'h2
`define MCS_SRC_USB            3'h3
`define MCS_SRC_CHG            3'h4
`define MCS_NUM_SRC            5
`define MCS_CH_USB0            4'h0
`define MCS_CH_CHG1            4'h1
`define MCS_CH_CHG4            4'h4
`define MCS_CH_VBAT            4'hc
`define MCS_CH_LAST            4'hf

// ****************************************
// timing
// ****************************************
`define MCS_SETTLE_BASE_US     11'h005
`define MCS_SETTLE_FIXED_US    11'h014
`define MCS_CLK_MHZ            10
`define MCS_AVG_LAST_REP       2'h3

`endif

// ==== logic/mcs_top.v ====
// monitor converter control and status: registers, request sequencing, settling and averaging
// assumes a register port from the serial front end on clk_sys, and an analog converter
// that answers each conv_start with one conv_done pulse carrying a 10-bit sample
//
// Functional notes
// RQ1: second-software averaging bits for channels 8, 12
// RQ2: averaging takes four conversions, stores mean
// RQ3: charger/usb averaging bits 5,4,1; 7:6 zero
// RQ4: settle 5-20us low nibble, high nibble extends
// RQ5: settling register resets to 0x07, 12us
// RQ6: charger and usb use fixed 20us settling
// RQ7: settling writes ignored while busy
// RQ8: host programs settling only when idle
// RQ9: threshold low bits 7:6 reset 3, rest zero
// RQ10: threshold high byte resets to 0x8c
// RQ11: usb threshold status bit 6, resets 1
// RQ12: battery threshold status bit 7, resets 1
// RQ13: start bit one starts first software sequence
// RQ14: start bit two starts second; zero ignored
// RQ15: first software done flag, resets 1
// RQ16: realtime done flag bit 2 in both
// RQ17: usb done flag bit 4 in both
// RQ18: interrupt pulse at end of sequences; the charger sequence pulses chg_data_ready_q instead
// RQ19: busy bit 0 shared, resets 0
// RQ20: charger done indication and data-ready pulse
// RQ21: comparator status duplicated in both controls
// RQ22: second software done flag, resets 1
// RQ23: only selected channels are converted
// RQ24: start bits pulse once, read zero
`timescale 1ns/10ps
`default_nettype none
`include "mcs_consts.vh"

module mcs_top #(
	parameter CYCLES_PER_US = `MCS_CLK_MHZ
) (
	input  wire        clk_sys,
	input  wire        rst_b,
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr_en,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_rd_en,
	output reg  [7:0]  reg_rdata_q,
	input  wire        rt_start_pin,
	input  wire        usb_req,
	input  wire        chg_req,
	input  wire [15:0] sw1_sel,
	input  wire [15:0] sw2_sel,
	input  wire [15:0] rt_sel,
	input  wire [15:0] usb_sel,
	input  wire [15:0] chg_sel,
	input  wire [15:0] sw1_avg,
	input  wire [15:0] rt_avg,
	input  wire [7:0]  sw2_avg_low,
	input  wire [9:0]  battery_threshold,
	output reg         conv_start_q,
	output reg  [3:0]  conv_channel_q,
	output reg  [15:0] conv_settle_q,
	input  wire        conv_done,
	input  wire [9:0]  conv_data,
	output reg         result_valid_q,
	output reg  [3:0]  result_channel_q,
	output reg  [2:0]  result_source_q,
	output reg  [9:0]  result_data_q,
	output reg         irq_q,
	output reg         chg_data_ready_q,
	output reg         done_charger_q
);

	// ****************************************
	// states
	// ****************************************
	localparam ST_IDLE   = 3'h0;
	localparam ST_SCAN   = 3'h1;
	localparam ST_SETTLE = 3'h2;
	localparam ST_CONV   = 3'h3;
	localparam ST_WAIT   = 3'h4;
	localparam ST_FINISH = 3'h5;
	localparam [15:0] CYC_US = CYCLES_PER_US[15:0];

	// ****************************************
	// registers
	// ****************************************
	reg  [7:0]  avg_two_high_q;
	reg  [5:0]  chg_usb_avg_q;
	reg  [7:0]  settle_q;
	reg  [1:0]  thr_low_q;
	reg  [7:0]  thr_high_q;
	reg         usb_sts_q;
	reg         bat_sts_q;
	reg  [2:0]  state_q;
	reg  [2:0]  src_q;
	reg  [3:0]  idx_q;
	reg  [1:0]  rep_q;
	reg  [11:0] acc_q;
	reg  [15:0] cnt_q;
	reg  [15:0] mask_q;
	reg  [15:0] avg_q;
	reg         rt_s1_q;
	reg         rt_s2_q;
	reg         rt_s3_q;
	reg  [4:0]  pend_q;
	reg  [4:0]  done_q;
	reg  [4:0]  grant;
	reg  [2:0]  pick;
	wire [4:0]  req_vec;
	wire [4:0]  fin_vec;
	wire        busy;
	wire        wr_ctrl_one;
	wire        wr_ctrl_two;
	wire [9:0]  usb_threshold;
	wire [10:0] prog_us;
	wire [10:0] settle_us;
	wire [15:0] settle_prod;
	wire [15:0] avg_sel_two;
	wire [15:0] avg_sel_usb;
	wire [15:0] avg_sel_chg;
	wire [11:0] acc_sum;
	wire [9:0]  sample;
	wire [7:0]  ctrl_one_rd;
	wire [7:0]  ctrl_two_rd;

	// ****************************************
	// request capture
	// ****************************************
	// realtime start arrives from a pin, so it is synchronised before edge detection
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rt_s1_q <= 1'b0;
			rt_s2_q <= 1'b0;
			rt_s3_q <= 1'b0;
		end else begin
			rt_s1_q <= rt_start_pin;
			rt_s2_q <= rt_s1_q;
			rt_s3_q <= rt_s2_q;
		end
	end

	assign wr_ctrl_one = reg_wr_en && (reg_addr == `MCS_ADDR_CTRL_ONE) && reg_wdata[`MCS_BIT_START]; // [RQ13] [RQ24]
	assign wr_ctrl_two = reg_wr_en && (reg_addr == `MCS_ADDR_CTRL_TWO) && reg_wdata[`MCS_BIT_START]; // [RQ14] [RQ24]

	assign req_vec[`MCS_SRC_SW1] = wr_ctrl_one;
	assign req_vec[`MCS_SRC_SW2] = wr_ctrl_two;
	assign req_vec[`MCS_SRC_RT]  = rt_s2_q & ~rt_s3_q;
	assign req_vec[`MCS_SRC_USB] = usb_req;
	assign req_vec[`MCS_SRC_CHG] = chg_req;

	// charger first: its data-ready gates the charging loop
	always @* begin
		grant = 5'h00;
		pick  = 3'h0;
		if (state_q == ST_IDLE) begin
			if (pend_q[`MCS_SRC_CHG]) begin
				grant[`MCS_SRC_CHG] = 1'b1;
				pick = `MCS_SRC_CHG;
			end else if (pend_q[`MCS_SRC_USB]) begin
				grant[`MCS_SRC_USB] = 1'b1;
				pick = `MCS_SRC_USB;
			end else if (pend_q[`MCS_SRC_RT]) begin
				grant[`MCS_SRC_RT] = 1'b1;
				pick = `MCS_SRC_RT;
			end else if (pend_q[`MCS_SRC_SW1]) begin
				grant[`MCS_SRC_SW1] = 1'b1;
				pick = `MCS_SRC_SW1;
			end else if (pend_q[`MCS_SRC_SW2]) begin
				grant[`MCS_SRC_SW2] = 1'b1;
				pick = `MCS_SRC_SW2;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < `MCS_NUM_SRC; g = g + 1) begin : g_src
			assign fin_vec[g] = (state_q == ST_FINISH) && (src_q == g);
			// a request in the grant cycle stays pending
			always @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					pend_q[g] <= 1'b0;
					done_q[g] <= 1'b1;
				end else begin
					if (req_vec[g])
						pend_q[g] <= 1'b1;
					else if (grant[g])
						pend_q[g] <= 1'b0;
					if (req_vec[g])
						done_q[g] <= 1'b0; // [RQ15] [RQ16] [RQ17] [RQ22]
					else if (fin_vec[g] && !pend_q[g])
						done_q[g] <= 1'b1; // [RQ15] [RQ16] [RQ17] [RQ22]
				end
			end
		end
	endgenerate

	assign busy = (state_q != ST_IDLE) || (pend_q != 5'h00); // [RQ19]

	// ****************************************
	// register writes
	// ****************************************
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			avg_two_high_q <= `MCS_RST_AVG;
			chg_usb_avg_q  <= 6'h00;
			settle_q       <= `MCS_RST_SETTLE; // [RQ5]
			thr_low_q      <= `MCS_RST_THR_LOW; // [RQ9]
			thr_high_q     <= `MCS_RST_THR_HIGH; // [RQ10]
		end else if (reg_wr_en) begin
			case (reg_addr)
				`MCS_ADDR_AVG_TWO_HIGH: avg_two_high_q <= reg_wdata;
				`MCS_ADDR_CHG_USB_AVG:  chg_usb_avg_q <= reg_wdata[5:0]; // [RQ3]
				`MCS_ADDR_SETTLE: begin
					// a mid-sequence change would alter settling between channels
					if (!busy)
						settle_q <= reg_wdata; // [RQ7]
				end
				`MCS_ADDR_THR_LOW:  thr_low_q <= reg_wdata[`MCS_THR_LOW_MSB:`MCS_THR_LOW_LSB]; // [RQ9]
				`MCS_ADDR_THR_HIGH: thr_high_q <= reg_wdata; // [RQ10]
				default: begin
				end
			endcase
		end
	end

	assign usb_threshold = {thr_high_q, thr_low_q};

	// ****************************************
	// settling and averaging selection
	// ****************************************
	// high nibble adds 64us steps, reaching 980us at full scale
	assign prog_us     = `MCS_SETTLE_BASE_US + {7'h00, settle_q[3:0]} + {1'b0, settle_q[7:4], 6'h00}; // [RQ4]
	assign settle_us   = ((src_q == `MCS_SRC_USB) || (src_q == `MCS_SRC_CHG)) ?
	                     `MCS_SETTLE_FIXED_US : prog_us; // [RQ6]
	assign settle_prod = {5'h00, settle_us} * CYC_US;

	assign avg_sel_two = {3'h0, avg_two_high_q[`MCS_BIT_AVG_CH12], 3'h0,
	                     avg_two_high_q[`MCS_BIT_AVG_CH8], sw2_avg_low}; // [RQ1]
	assign avg_sel_usb = {15'h0000, chg_usb_avg_q[`MCS_BIT_USB_AVG_CH0]}; // [RQ3]
	assign avg_sel_chg = {11'h000, chg_usb_avg_q[`MCS_BIT_CHG_AVG_CH4], 2'h0,
	                     chg_usb_avg_q[`MCS_BIT_CHG_AVG_CH1], 1'b0}; // [RQ3]

	assign acc_sum = acc_q + {2'h0, conv_data};
	assign sample  = avg_q[idx_q] ? acc_sum[11:2] : conv_data; // [RQ2]

	// ****************************************
	// sequencer
	// ****************************************
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q          <= ST_IDLE;
			src_q            <= 3'h0;
			idx_q            <= 4'h0;
			rep_q            <= 2'h0;
			acc_q            <= 12'h000;
			cnt_q            <= 16'h0000;
			mask_q           <= 16'h0000;
			avg_q            <= 16'h0000;
			conv_start_q     <= 1'b0;
			conv_channel_q   <= 4'h0;
			conv_settle_q    <= 16'h0000;
			result_valid_q   <= 1'b0;
			result_channel_q <= 4'h0;
			result_source_q  <= 3'h0;
			result_data_q    <= 10'h000;
			usb_sts_q        <= 1'b1; // [RQ11]
			bat_sts_q        <= 1'b1; // [RQ12]
			irq_q            <= 1'b0;
			chg_data_ready_q <= 1'b0;
			done_charger_q   <= 1'b1;
		end else begin
			conv_start_q     <= 1'b0;
			result_valid_q   <= 1'b0;
			irq_q            <= 1'b0;
			chg_data_ready_q <= 1'b0;
			if (req_vec[`MCS_SRC_CHG])
				done_charger_q <= 1'b0; // [RQ20]
			case (state_q)
				ST_IDLE: begin
					if (grant != 5'h00) begin
						src_q   <= pick;
						idx_q   <= 4'h0;
						state_q <= ST_SCAN;
						case (pick)
							`MCS_SRC_SW1: begin
								mask_q <= sw1_sel;
								avg_q  <= sw1_avg;
							end
							`MCS_SRC_SW2: begin
								mask_q <= sw2_sel;
								avg_q  <= avg_sel_two; // [RQ1]
							end
							`MCS_SRC_RT: begin
								mask_q <= rt_sel;
								avg_q  <= rt_avg;
							end
							`MCS_SRC_USB: begin
								mask_q <= usb_sel;
								avg_q  <= avg_sel_usb;
							end
							default: begin
								mask_q <= chg_sel;
								avg_q  <= avg_sel_chg;
							end
						endcase
					end
				end
				ST_SCAN: begin
					if (mask_q[idx_q]) begin
						cnt_q         <= settle_prod[15:0];
						conv_settle_q <= settle_prod[15:0];
						rep_q         <= 2'h0;
						acc_q         <= 12'h000;
						state_q       <= ST_SETTLE; // [RQ23]
					end else if (idx_q == `MCS_CH_LAST) begin
						state_q <= ST_FINISH;
					end else begin
						idx_q <= idx_q + 4'h1; // [RQ23]
					end
				end
				ST_SETTLE: begin
					if (cnt_q <= 16'h0001)
						state_q <= ST_CONV;
					else
						cnt_q <= cnt_q - 16'h0001; // [RQ4] [RQ6]
				end
				ST_CONV: begin
					conv_start_q   <= 1'b1;
					conv_channel_q <= idx_q;
					state_q        <= ST_WAIT;
				end
				ST_WAIT: begin
					if (conv_done) begin
						if (avg_q[idx_q] && (rep_q != `MCS_AVG_LAST_REP)) begin
							acc_q   <= acc_sum;
							rep_q   <= rep_q + 2'h1;
							state_q <= ST_CONV; // [RQ2]
						end else begin
							result_valid_q   <= 1'b1;
							result_channel_q <= idx_q;
							result_source_q  <= src_q;
							result_data_q    <= sample; // [RQ2]
							if (idx_q == `MCS_CH_VBAT) begin
								usb_sts_q <= (sample > usb_threshold); // [RQ11]
								bat_sts_q <= (sample > battery_threshold); // [RQ12]
							end
							if (idx_q == `MCS_CH_LAST) begin
								state_q <= ST_FINISH;
							end else begin
								idx_q   <= idx_q + 4'h1;
								state_q <= ST_SCAN;
							end
						end
					end
				end
				ST_FINISH: begin
					state_q <= ST_IDLE;
					if (src_q == `MCS_SRC_CHG) begin
						chg_data_ready_q <= 1'b1; // [RQ20]
						if (!pend_q[`MCS_SRC_CHG] && !req_vec[`MCS_SRC_CHG])
							done_charger_q <= 1'b1; // [RQ20]
					end else begin
						irq_q <= 1'b1; // [RQ18]
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	// both control views share busy, realtime and usb done and comparator bits; bit 1 is each view's own software done; start bits read zero
	assign ctrl_one_rd = {bat_sts_q, usb_sts_q, 1'b0, done_q[`MCS_SRC_USB], 1'b1,
	                     done_q[`MCS_SRC_RT], done_q[`MCS_SRC_SW1], busy}; // [RQ19] [RQ21] [RQ24]
	assign ctrl_two_rd = {bat_sts_q, usb_sts_q, 1'b0, done_q[`MCS_SRC_USB], 1'b1,
	                     done_q[`MCS_SRC_RT], done_q[`MCS_SRC_SW2], busy}; // [RQ16] [RQ17] [RQ21]

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd_en) begin
			case (reg_addr)
				`MCS_ADDR_AVG_TWO_HIGH: reg_rdata_q <= avg_two_high_q;
				`MCS_ADDR_CHG_USB_AVG:  reg_rdata_q <= {2'h0, chg_usb_avg_q}; // [RQ3]
				`MCS_ADDR_SETTLE:       reg_rdata_q <= settle_q;
				`MCS_ADDR_THR_LOW:      reg_rdata_q <= {thr_low_q, 6'h00}; // [RQ9]
				`MCS_ADDR_THR_HIGH:     reg_rdata_q <= thr_high_q;
				`MCS_ADDR_CTRL_ONE:     reg_rdata_q <= ctrl_one_rd;
				`MCS_ADDR_CTRL_TWO:     reg_rdata_q <= ctrl_two_rd;
				default:                reg_rdata_q <= 8'h00;
			endcase
		end
	end

endmodule

`default_nettype wire
